// >>> rtl/tba_pkg.sv
package tba_pkg;

	// ----------------------------------------------------------------
	// frame bytes
	// ----------------------------------------------------------------
	localparam logic [7:0] FRM_SYNC0  = 8'hff;
	localparam logic [7:0] FRM_SYNC1  = 8'h00;

	// ----------------------------------------------------------------
	// command bytes
	// ----------------------------------------------------------------
	localparam logic [7:0] CMD_RD_VAL = 8'h87;
	localparam logic [7:0] CMD_WR_BLK = 8'h89;
	localparam logic [7:0] CMD_WR_VAL = 8'h8a;
	localparam logic [7:0] CMD_WR_PG4 = 8'h8b;

	// ----------------------------------------------------------------
	// command and answer length bytes
	// ----------------------------------------------------------------
	localparam logic [7:0] LEN_RD_VAL = 8'h02;
	localparam logic [7:0] LEN_WR_BLK = 8'h12;
	localparam logic [7:0] LEN_WR_VAL = 8'h06;
	localparam logic [7:0] LEN_WR_PG4 = 8'h06;
	localparam logic [7:0] LEN_OK_4B  = 8'h06;
	localparam logic [7:0] LEN_OK_16B = 8'h12;
	localparam logic [7:0] LEN_FAIL   = 8'h02;

	// ----------------------------------------------------------------
	// error codes
	// ----------------------------------------------------------------
	localparam logic [7:0] ERR_NONE     = 8'h00;
	localparam logic [7:0] ERR_NO_TAG   = 8'h4e;
	localparam logic [7:0] ERR_INVALID  = 8'h49;
	localparam logic [7:0] ERR_FAILED   = 8'h46;
	localparam logic [7:0] ERR_MISMATCH = 8'h55;
	localparam logic [7:0] ERR_NO_READ  = 8'h58;

	// ----------------------------------------------------------------
	// tag engine operations
	// ----------------------------------------------------------------
	localparam logic [1:0] OP_READ  = 2'h0;
	localparam logic [1:0] OP_WR16  = 2'h1;
	localparam logic [1:0] OP_WR4   = 2'h2;

	// ----------------------------------------------------------------
	// sizes and reset values
	// ----------------------------------------------------------------
	localparam int         BLK_BYTES  = 16;
	localparam logic [4:0] LOAD_LAST  = 5'h10;
	localparam logic [7:0] RST_BYTE   = 8'h00;

	typedef enum logic [3:0] {
		ST_IDLE, ST_HDR, ST_LEN, ST_CMD, ST_PAY, ST_CSUM,
		ST_LOAD, ST_EXEC, ST_WAITW, ST_WAITR, ST_TX
	} tba_state_t;

endpackage

// >>> rtl/tba_mem.sv
`timescale 1ns/1ps
module tba_mem (
	input  wire logic       i_mclk,
	input  wire logic       i_we,
	input  wire logic [3:0] i_waddr,
	input  wire logic [7:0] i_wdata,
	input  wire logic [3:0] i_raddr,
	output logic      [7:0] o_rdata
);

	logic [7:0] mem [0:15];

	always_ff @(posedge i_mclk) begin
		if (i_we) begin
			mem[i_waddr] <= i_wdata;
		end
		o_rdata <= mem[i_raddr];
	end

endmodule // tba_mem

// >>> rtl/tba_core.sv
// Overview of operation
// - value read ok: len 06, cmd, block, value
// - value read fail: len 02, 4E/49/46
// - value read fails unauthenticated or bad format
// - block write rejected unless block authenticated
// - block write verified: 55 mismatch, 58 unreadable
// - block write ok: len 12, cmd, block, data
// - block write fail: 4E no tag, 46
// - value write builds format, writes, reads back
// - value write ok: len 06, readback value
// - value write fail: len 02, 4E/49/46
// - page write ok: len 06, readback bytes
// - page write fail: 55, 58, 4E, 46
`timescale 1ns/1ps
module tba_core (
	input  wire logic         i_mclk,
	input  wire logic         i_sys_rst,
	input  wire logic         i_rx_valid,
	input  wire logic [7:0]   i_rx_data,
	input  wire logic         i_tx_ready,
	output logic              o_tx_valid,
	output logic      [7:0]   o_tx_data,
	input  wire logic         i_tag_present,
	input  wire logic         i_auth_valid,
	input  wire logic [7:0]   i_auth_blk,
	output logic              o_tag_req,
	output logic      [1:0]   o_tag_op,
	output logic      [7:0]   o_tag_blk,
	output logic      [127:0] o_tag_wdata,
	input  wire logic         i_tag_done,
	input  wire logic         i_tag_ok,
	input  wire logic [127:0] i_tag_rdata,
	output logic              o_busy
);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	tba_pkg::tba_state_t st_r, st_nxt;
	logic [7:0]   len_r, len_nxt;
	logic [7:0]   cmd_r, cmd_nxt;
	logic [7:0]   blk_r, blk_nxt;
	logic [7:0]   sum_r, sum_nxt;
	logic [7:0]   pidx_r, pidx_nxt;
	logic [4:0]   ld_r, ld_nxt;
	logic [127:0] wdata_r, wdata_nxt;
	logic [127:0] rb_r, rb_nxt;
	logic [7:0]   err_r, err_nxt;
	logic [7:0]   rlen_r, rlen_nxt;
	logic         req_r, req_nxt;
	logic [1:0]   op_r, op_nxt;
	logic         txv_r, txv_nxt;
	logic [7:0]   txd_r, txd_nxt;
	logic [7:0]   tidx_r, tidx_nxt;
	logic [7:0]   tsum_r, tsum_nxt;
	logic [7:0]   mem_rdata;

	// ----------------------------------------------------------------
	// value block format helpers
	// ----------------------------------------------------------------
	function automatic logic [127:0] fmt_value(input logic [31:0] v, input logic [7:0] a);
		fmt_value = {~a, a, ~a, a, v, ~v, v};
	endfunction

	function automatic logic val_ok(input logic [127:0] d);
		val_ok = (d[63:32] == ~d[31:0]) && (d[95:64] == d[31:0])
			&& (d[111:104] == ~d[103:96]) && (d[119:112] == d[103:96])
			&& (d[127:120] == ~d[103:96]);
	endfunction

	// ----------------------------------------------------------------
	// decode
	// ----------------------------------------------------------------
	wire [7:0] rx_sum     = sum_r + i_rx_data;
	wire       pay_last   = (pidx_r + 8'h02) == len_r;
	wire       mem_we     = (st_r == tba_pkg::ST_PAY) && i_rx_valid
		&& (pidx_r != 8'h00) && (pidx_r <= 8'h10);
	wire [3:0] mem_waddr  = 4'(pidx_r - 8'h01);
	wire [3:0] mem_raddr  = ld_r[3:0];
	wire       is_rdv     = cmd_r == tba_pkg::CMD_RD_VAL;
	wire       is_wrb     = cmd_r == tba_pkg::CMD_WR_BLK;
	wire       is_wrv     = cmd_r == tba_pkg::CMD_WR_VAL;
	wire       is_wr4     = cmd_r == tba_pkg::CMD_WR_PG4;
	wire       len_ok     = (is_rdv && len_r == tba_pkg::LEN_RD_VAL)
		|| (is_wrb && len_r == tba_pkg::LEN_WR_BLK)
		|| (is_wrv && len_r == tba_pkg::LEN_WR_VAL)
		|| (is_wr4 && len_r == tba_pkg::LEN_WR_PG4);
	wire       auth_hit   = i_auth_valid && (i_auth_blk == blk_r);
	wire       need_auth  = is_rdv || is_wrb || is_wrv;
	wire       wr16_match = i_tag_rdata == wdata_r;
	wire       wr4_match  = i_tag_rdata[31:0] == wdata_r[31:0];
	wire       rd_good    = (is_rdv || is_wrv) ? val_ok(i_tag_rdata)
		: (is_wrb ? wr16_match : wr4_match);
	wire [7:0] rd_err     = (is_rdv || is_wrv) ? tba_pkg::ERR_INVALID
		: tba_pkg::ERR_MISMATCH;
	wire [7:0] nord_err   = (is_rdv || is_wrv) ? tba_pkg::ERR_FAILED
		: tba_pkg::ERR_NO_READ;
	wire [7:0] ok_len     = is_wrb ? tba_pkg::LEN_OK_16B : tba_pkg::LEN_OK_4B;

	// transmit byte selection for the next frame position
	wire       tx_go      = txv_r && i_tx_ready;
	wire [7:0] tx_next    = tidx_r + 8'h01;
	wire [7:0] tsum_acc   = (tidx_r != 8'h00) ? tsum_r + txd_r : tsum_r;
	wire [7:0] tx_last    = rlen_r + 8'h03;
	wire [7:0] tx_p       = tx_next - 8'h04;
	wire [3:0] tx_pm1     = 4'(tx_p - 8'h01);
	wire [7:0] tx_pay     = (err_r != tba_pkg::ERR_NONE) ? err_r
		: ((tx_p == 8'h00) ? blk_r : rb_r[8*tx_pm1 +: 8]);
	wire [7:0] tx_sel     = (tx_next == 8'h01) ? tba_pkg::FRM_SYNC1
		: (tx_next == 8'h02) ? rlen_r
		: (tx_next == 8'h03) ? cmd_r
		: (tx_next == tx_last) ? tsum_acc
		: tx_pay;

	// ----------------------------------------------------------------
	// payload store
	// ----------------------------------------------------------------
	tba_mem u_mem (
		.i_mclk  (i_mclk),
		.i_we    (mem_we),
		.i_waddr (mem_waddr),
		.i_wdata (i_rx_data),
		.i_raddr (mem_raddr),
		.o_rdata (mem_rdata)
	);

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		st_nxt    = st_r;
		len_nxt   = len_r;
		cmd_nxt   = cmd_r;
		blk_nxt   = blk_r;
		sum_nxt   = sum_r;
		pidx_nxt  = pidx_r;
		ld_nxt    = ld_r;
		wdata_nxt = wdata_r;
		rb_nxt    = rb_r;
		err_nxt   = err_r;
		rlen_nxt  = rlen_r;
		req_nxt   = 1'b0;
		op_nxt    = op_r;
		txv_nxt   = txv_r;
		txd_nxt   = txd_r;
		tidx_nxt  = tidx_r;
		tsum_nxt  = tsum_r;
		case (st_r)
			tba_pkg::ST_IDLE: begin
				if (i_rx_valid && i_rx_data == tba_pkg::FRM_SYNC0) begin
					st_nxt = tba_pkg::ST_HDR;
				end
			end
			tba_pkg::ST_HDR: begin
				if (i_rx_valid) begin
					if (i_rx_data == tba_pkg::FRM_SYNC1) begin
						st_nxt = tba_pkg::ST_LEN;
					end else if (i_rx_data != tba_pkg::FRM_SYNC0) begin
						st_nxt = tba_pkg::ST_IDLE;
					end
				end
			end
			tba_pkg::ST_LEN: begin
				if (i_rx_valid) begin
					len_nxt = i_rx_data;
					sum_nxt = i_rx_data;
					st_nxt  = (i_rx_data == 8'h00) ? tba_pkg::ST_IDLE : tba_pkg::ST_CMD;
				end
			end
			tba_pkg::ST_CMD: begin
				if (i_rx_valid) begin
					cmd_nxt  = i_rx_data;
					sum_nxt  = rx_sum;
					pidx_nxt = 8'h00;
					st_nxt   = (len_r == 8'h01) ? tba_pkg::ST_CSUM : tba_pkg::ST_PAY;
				end
			end
			tba_pkg::ST_PAY: begin
				if (i_rx_valid) begin
					// first payload byte is the block number, the rest go to the store
					if (pidx_r == 8'h00) begin
						blk_nxt = i_rx_data;
					end
					sum_nxt  = rx_sum;
					pidx_nxt = pidx_r + 8'h01;
					if (pay_last) begin
						st_nxt = tba_pkg::ST_CSUM;
					end
				end
			end
			tba_pkg::ST_CSUM: begin
				if (i_rx_valid) begin
					// bad checksum, unknown command or wrong length drops the frame
					if (i_rx_data == sum_r && len_ok) begin
						ld_nxt = 5'h00;
						st_nxt = is_rdv ? tba_pkg::ST_EXEC : tba_pkg::ST_LOAD;
					end else begin
						st_nxt = tba_pkg::ST_IDLE;
					end
				end
			end
			tba_pkg::ST_LOAD: begin
				// store read data lags the address by one cycle
				ld_nxt = ld_r + 5'h01;
				if (ld_r != 5'h00) begin
					wdata_nxt = {mem_rdata, wdata_r[127:8]};
				end
				if (ld_r == tba_pkg::LOAD_LAST) begin
					st_nxt = tba_pkg::ST_EXEC;
					if (is_wrv) begin
						wdata_nxt = fmt_value(wdata_r[39:8], blk_r);
					end else if (is_wr4) begin
						wdata_nxt = {96'h0, wdata_r[39:8]};
					end
				end
			end
			tba_pkg::ST_EXEC: begin
				if (!i_tag_present) begin
					err_nxt = tba_pkg::ERR_NO_TAG;
					st_nxt  = tba_pkg::ST_TX;
				end else if (need_auth && !auth_hit) begin
					err_nxt = tba_pkg::ERR_FAILED;
					st_nxt  = tba_pkg::ST_TX;
				end else if (is_rdv) begin
					req_nxt = 1'b1;
					op_nxt  = tba_pkg::OP_READ;
					st_nxt  = tba_pkg::ST_WAITR;
				end else begin
					req_nxt = 1'b1;
					op_nxt  = is_wr4 ? tba_pkg::OP_WR4 : tba_pkg::OP_WR16;
					st_nxt  = tba_pkg::ST_WAITW;
				end
			end
			tba_pkg::ST_WAITW: begin
				if (i_tag_done) begin
					if (i_tag_ok) begin
						req_nxt = 1'b1;
						op_nxt  = tba_pkg::OP_READ;
						st_nxt  = tba_pkg::ST_WAITR;
					end else begin
						err_nxt = tba_pkg::ERR_FAILED;
						st_nxt  = tba_pkg::ST_TX;
					end
				end
			end
			tba_pkg::ST_WAITR: begin
				if (i_tag_done) begin
					rb_nxt = i_tag_rdata;
					st_nxt = tba_pkg::ST_TX;
					if (!i_tag_ok) begin
						err_nxt = nord_err;
					end else if (!rd_good) begin
						err_nxt = rd_err;
					end
				end
			end
			tba_pkg::ST_TX: begin
				if (!txv_r) begin
					// answer length follows the outcome
					rlen_nxt = (err_r != tba_pkg::ERR_NONE) ? tba_pkg::LEN_FAIL
						: ok_len;
					txv_nxt  = 1'b1;
					txd_nxt  = tba_pkg::FRM_SYNC0;
					tidx_nxt = 8'h00;
					tsum_nxt = 8'h00;
				end else if (tx_go) begin
					tsum_nxt = tsum_acc;
					tidx_nxt = tx_next;
					txd_nxt  = tx_sel;
					if (tidx_r == tx_last) begin
						txv_nxt = 1'b0;
						err_nxt = tba_pkg::ERR_NONE;
						st_nxt  = tba_pkg::ST_IDLE;
					end
				end
			end
			default: begin
				st_nxt = tba_pkg::ST_IDLE;
			end
		endcase
	end

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	always_ff @(posedge i_mclk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			st_r    <= tba_pkg::ST_IDLE;
			len_r   <= tba_pkg::RST_BYTE;
			cmd_r   <= tba_pkg::RST_BYTE;
			blk_r   <= tba_pkg::RST_BYTE;
			sum_r   <= tba_pkg::RST_BYTE;
			pidx_r  <= tba_pkg::RST_BYTE;
			ld_r    <= 5'h00;
			wdata_r <= 128'h0;
			rb_r    <= 128'h0;
			err_r   <= tba_pkg::ERR_NONE;
			rlen_r  <= tba_pkg::RST_BYTE;
			req_r   <= 1'b0;
			op_r    <= tba_pkg::OP_READ;
			txv_r   <= 1'b0;
			txd_r   <= tba_pkg::RST_BYTE;
			tidx_r  <= tba_pkg::RST_BYTE;
			tsum_r  <= tba_pkg::RST_BYTE;
		end else begin
			st_r    <= st_nxt;
			len_r   <= len_nxt;
			cmd_r   <= cmd_nxt;
			blk_r   <= blk_nxt;
			sum_r   <= sum_nxt;
			pidx_r  <= pidx_nxt;
			ld_r    <= ld_nxt;
			wdata_r <= wdata_nxt;
			rb_r    <= rb_nxt;
			err_r   <= err_nxt;
			rlen_r  <= rlen_nxt;
			req_r   <= req_nxt;
			op_r    <= op_nxt;
			txv_r   <= txv_nxt;
			txd_r   <= txd_nxt;
			tidx_r  <= tidx_nxt;
			tsum_r  <= tsum_nxt;
		end
	end

	logic busy_r;

	always_ff @(posedge i_mclk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			busy_r <= 1'b0;
		end else begin
			busy_r <= st_nxt > tba_pkg::ST_CSUM;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign o_tx_valid  = txv_r;
	assign o_tx_data   = txd_r;
	assign o_tag_req   = req_r;
	assign o_tag_op    = op_r;
	assign o_tag_blk   = blk_r;
	assign o_tag_wdata = wdata_r;
	assign o_busy      = busy_r;

endmodule // tba_core

// >>> verif/tba_core_asserts.sv
`timescale 1ns/1ps
module tba_chk (
	input  wire logic         i_mclk,
	input  wire logic         i_sys_rst,
	input  wire logic         i_tx_ready,
	input  wire logic         o_tx_valid,
	input  wire logic [7:0]   o_tx_data,
	input  wire logic         i_auth_valid,
	input  wire logic [7:0]   i_auth_blk,
	input  wire logic         i_tag_present,
	input  wire logic         o_tag_req,
	input  wire logic [1:0]   o_tag_op,
	input  wire logic [7:0]   o_tag_blk,
	input  wire logic [127:0] o_tag_wdata,
	input  wire logic         i_tag_done,
	input  wire logic         i_tag_ok,
	input  wire logic         o_busy
);
	// ----------------------------------------------------------------
	// index of the answer byte on offer
	// ----------------------------------------------------------------
	logic [4:0] idx_r;
	logic [4:0] idx_nxt;
	assign idx_nxt = !o_tx_valid ? 5'h00 : (i_tx_ready ? idx_r + 5'h01 : idx_r);
	always_ff @(posedge i_mclk or posedge i_sys_rst) begin
		if (i_sys_rst)
			idx_r <= 5'h00;
		else
			idx_r <= idx_nxt;
	end
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (i_sys_rst);
	// ----------------------------------------------------------------
	// properties
	// ----------------------------------------------------------------
	property p_req_pulse;
		o_tag_req |=> !o_tag_req;
	endproperty
	a_req_pulse: assert property (p_req_pulse) else $error("tag request too long");
	property p_tx_hold;
		o_tx_valid && !i_tx_ready |=> o_tx_valid && $stable(o_tx_data);
	endproperty
	a_tx_hold: assert property (p_tx_hold) else $error("answer byte dropped");
	property p_sync0;
		o_tx_valid && idx_r == 5'h00 |-> o_tx_data == 8'hff;
	endproperty
	a_sync0: assert property (p_sync0) else $error("first sync byte wrong");
	property p_sync1;
		o_tx_valid && idx_r == 5'h01 |-> o_tx_data == 8'h00;
	endproperty
	a_sync1: assert property (p_sync1) else $error("second sync byte wrong");
	property p_len;
		o_tx_valid && idx_r == 5'h02 |-> o_tx_data inside {8'h02, 8'h06, 8'h12};
	endproperty
	a_len: assert property (p_len) else $error("answer length wrong");
	property p_wr_auth;
		o_tag_req && o_tag_op == tba_pkg::OP_WR16
			|-> i_tag_present && i_auth_valid && o_tag_blk == i_auth_blk;
	endproperty
	a_wr_auth: assert property (p_wr_auth) else $error("write without login");
	property p_verify;
		i_tag_done && i_tag_ok && o_tag_op != tba_pkg::OP_READ
			|=> o_tag_req && o_tag_op == tba_pkg::OP_READ && $stable(o_tag_blk);
	endproperty
	a_verify: assert property (p_verify) else $error("no read back");
	property p_wfail;
		i_tag_done && !i_tag_ok && o_tag_op != tba_pkg::OP_READ
			|=> !o_tag_req ##[1:3] o_tx_valid;
	endproperty
	a_wfail: assert property (p_wfail) else $error("write failure not answered");
	property p_stable;
		o_tag_req |=> $stable(o_tag_wdata);
	endproperty
	a_stable: assert property (p_stable) else $error("write data moved");
	property p_busy;
		o_tx_valid || o_tag_req |-> o_busy;
	endproperty
	a_busy: assert property (p_busy) else $error("busy low during command");
endmodule // tba_chk

// >>> verif/tba_host.sv
`timescale 1ns/1ps
module tba_host (
	input  wire logic       i_mclk,
	output logic            o_rx_valid,
	output logic      [7:0] o_rx_data,
	output logic            o_tx_ready,
	input  wire logic       i_tx_valid,
	input  wire logic [7:0] i_tx_data
);
	logic       slow = 1'b0;
	logic       bad = 1'b0;
	logic [7:0] rsp[$];
	initial begin
		o_rx_valid = 1'b0;
		o_rx_data = 8'h00;
		o_tx_ready = 1'b1;
	end
	// slow mode takes an answer byte every other cycle
	always @(posedge i_mclk)
		o_tx_ready <= slow ? ~o_tx_ready : 1'b1;
	// one frame out, then collect one answer frame
	task automatic send(input logic [7:0] c, input logic [7:0] p[$]);
		logic [7:0] f[$];
		logic [7:0] s;
		int         n;
		f = {8'hff, 8'h00, 8'(p.size() + 1), c, p};
		s = 8'h00;
		for (int i = 2; i < f.size(); i++)
			s += f[i];
		f.push_back(s + {7'h00, bad});
		foreach (f[i]) begin
			@(posedge i_mclk);
			o_rx_valid <= 1'b1;
			o_rx_data <= f[i];
		end
		@(posedge i_mclk);
		o_rx_valid <= 1'b0;
		o_rx_data <= ~f[f.size() - 1];
		rsp.delete();
		n = 0;
		// next command after the whole answer is in, or after 400 cycles without it
		while (n < 400 && !(rsp.size() > 3 && rsp.size() == rsp[2] + 4)) begin
			@(posedge i_mclk);
			n++;
			if (i_tx_valid && o_tx_ready)
				rsp.push_back(i_tx_data);
		end
	endtask
endmodule // tba_host

// >>> verif/tb_tag_block_access_cmds.sv
`timescale 1ns/1ps
`define CK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin n_mismatch++; \
	$display("[FAIL] %s exp %h got %h", nm, e, g); end end
module tb_tag_block_access_cmds;
	logic         i_mclk = 1'b0;
	logic         i_sys_rst = 1'b1;
	logic         rx_valid, tx_ready, tx_valid, tag_req, tag_done = 1'b0, tag_ok = 1'b0;
	logic [7:0]   rx_data, tx_data, tag_blk, auth_blk = 8'h08;
	logic [3:0]   ctl = 4'hf;
	logic [1:0]   tag_op, opq = 2'h0;
	logic [2:0]   dly = 3'h0;
	logic [127:0] tag_wdata, wq = '0, mem = '0, flip = '0, tag_rdata = '0;
	logic         fin;
	logic         busy;
	int           n_mismatch = 0, n_tests = 0, cyc = 0;
	tba_core dut (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_rx_valid(rx_valid),
		.i_rx_data(rx_data), .i_tx_ready(tx_ready), .o_tx_valid(tx_valid),
		.o_tx_data(tx_data), .i_tag_present(ctl[3]), .i_auth_valid(ctl[2]),
		.i_auth_blk(auth_blk), .o_tag_req(tag_req), .o_tag_op(tag_op), .o_tag_blk(tag_blk),
		.o_tag_wdata(tag_wdata), .i_tag_done(tag_done), .i_tag_ok(tag_ok),
		.i_tag_rdata(tag_rdata), .o_busy(busy));
	tba_host host (.i_mclk(i_mclk), .o_rx_valid(rx_valid), .o_rx_data(rx_data),
		.o_tx_ready(tx_ready), .i_tx_valid(tx_valid), .i_tx_data(tx_data));
	always #4 i_mclk = ~i_mclk;
	// ----------------------------------------------------------------
	// tag engine: ctl = {present, login, write ok, read ok}
	// ----------------------------------------------------------------
	assign fin = dly == 3'h1 && !tag_req;
	always @(posedge i_mclk) begin
		tag_done <= fin;
		tag_ok <= fin ? (opq == tba_pkg::OP_READ ? ctl[0] : ctl[1]) : ~tag_ok;
		tag_rdata <= fin ? mem ^ flip : ~tag_rdata;
		dly <= tag_req ? 3'h3 : (dly != 3'h0 ? dly - 3'h1 : 3'h0);
		if (tag_req) begin
			opq <= tag_op;
			wq <= tag_wdata;
		end
		if (fin && ctl[1] && opq == tba_pkg::OP_WR16)
			mem <= wq;
		if (fin && ctl[1] && opq == tba_pkg::OP_WR4)
			mem[31:0] <= wq[31:0];
	end
	function automatic logic [127:0] vfmt(input logic [31:0] v, input logic [7:0] a);
		return {~a, a, ~a, a, v, ~v, v};
	endfunction
	task automatic cfg(input logic [3:0] c, input logic [7:0] ab, input logic [127:0] f);
		@(posedge i_mclk);
		ctl <= c;
		auth_blk <= ab;
		flip <= f;
	endtask
	task automatic go(input logic [7:0] c, input logic [7:0] p[$], input logic [7:0] e[$]);
		logic [7:0] f[$];
		logic [7:0] s;
		f = {8'hff, 8'h00, 8'(e.size() + 1), c, e};
		s = 8'h00;
		for (int i = 2; i < f.size(); i++)
			s += f[i];
		f.push_back(s);
		host.send(c, p);
		`CK("rsp_size", f.size(), host.rsp.size())
		foreach (f[i]) `CK("rsp_byte", f[i], host.rsp[i])
	endtask
	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic t_rd_val;
		mem = vfmt(32'h00002710, 8'h08);
		go(8'h87, {8'h08}, {8'h08, 8'h10, 8'h27, 8'h00, 8'h00});
		cfg(4'hf, 8'h08, 128'h1 << 40);
		go(8'h87, {8'h08}, {8'h49});
		cfg(4'he, 8'h08, '0);
		go(8'h87, {8'h08}, {8'h46});
		cfg(4'hf, 8'h09, '0);
		go(8'h87, {8'h08}, {8'h46});
		cfg(4'h7, 8'h08, '0);
		go(8'h87, {8'h08}, {8'h4e});
	endtask
	task automatic t_wr_blk;
		logic [7:0] p[$];
		p = {8'h0a};
		for (int i = 0; i < 16; i++)
			p.push_back(8'(i * 17 + 3));
		cfg(4'hf, 8'h0a, '0);
		go(8'h89, p, p);
		cfg(4'hf, 8'h0a, 128'h1 << 120);
		go(8'h89, p, {8'h55});
		cfg(4'he, 8'h0a, '0);
		go(8'h89, p, {8'h58});
		cfg(4'hd, 8'h0a, '0);
		go(8'h89, p, {8'h46});
		cfg(4'hf, 8'h0b, '0);
		go(8'h89, p, {8'h46});
		cfg(4'h7, 8'h0a, '0);
		go(8'h89, p, {8'h4e});
	endtask
	task automatic t_wr_val;
		cfg(4'hf, 8'h08, '0);
		go(8'h8a, {8'h08, 8'h10, 8'h27, 8'h00, 8'h00}, {8'h08, 8'h10, 8'h27, 8'h00, 8'h00});
		`CK("val_fmt", vfmt(32'h00002710, 8'h08), mem)
		cfg(4'hf, 8'h08, 128'h1 << 32);
		go(8'h8a, {8'h08, 8'hfe, 8'hff, 8'hff, 8'hff}, {8'h49});
		cfg(4'he, 8'h08, '0);
		go(8'h8a, {8'h08, 8'h01, 8'h00, 8'h00, 8'h80}, {8'h46});
		cfg(4'h7, 8'h08, '0);
		go(8'h8a, {8'h08, 8'h01, 8'h00, 8'h00, 8'h80}, {8'h4e});
	endtask
	task automatic t_reset;
		@(posedge i_mclk);
		i_sys_rst <= 1'b1;
		repeat (2) @(posedge i_mclk);
		`CK("rst_txv", 1'b0, tx_valid)
		`CK("rst_txd", 8'h00, tx_data)
		`CK("rst_req", 1'b0, tag_req)
		`CK("rst_op", 2'h0, tag_op)
		`CK("rst_blk", 8'h00, tag_blk)
		`CK("rst_wdata", 128'h0, tag_wdata)
		`CK("rst_busy", 1'b0, busy)
		i_sys_rst <= 1'b0;
	endtask
	task automatic t_wr_pg;
		host.slow = 1'b1;
		cfg(4'hb, 8'h00, '0);
		go(8'h8b, {8'h04, 8'haa, 8'hbb, 8'hcc, 8'hdd}, {8'h04, 8'haa, 8'hbb, 8'hcc, 8'hdd});
		cfg(4'hb, 8'h00, 128'h1);
		go(8'h8b, {8'h04, 8'h11, 8'h22, 8'h33, 8'h44}, {8'h55});
		cfg(4'ha, 8'h00, '0);
		go(8'h8b, {8'h04, 8'h11, 8'h22, 8'h33, 8'h44}, {8'h58});
		cfg(4'h9, 8'h00, '0);
		go(8'h8b, {8'h04, 8'h11, 8'h22, 8'h33, 8'h44}, {8'h46});
		cfg(4'h3, 8'h00, '0);
		go(8'h8b, {8'h04, 8'h11, 8'h22, 8'h33, 8'h44}, {8'h4e});
		host.slow = 1'b0;
	endtask
	task automatic t_refuse;
		cfg(4'hf, 8'h08, '0);
		host.bad = 1'b1;
		host.send(8'h87, {8'h08});
		`CK("no_answer", 0, host.rsp.size())
		host.bad = 1'b0;
		mem = vfmt(32'h80000001, 8'h08);
		go(8'h87, {8'h08}, {8'h08, 8'h01, 8'h00, 8'h00, 8'h80});
	endtask
	task automatic conclude;
		if (n_mismatch == 0 && n_tests > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	always @(posedge i_mclk) begin
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			n_mismatch++;
			conclude;
		end
	end
	initial begin
		repeat (20) @(posedge i_mclk);
		i_sys_rst <= 1'b0;
		t_rd_val;
		t_wr_blk;
		t_wr_val;
		t_reset;
		t_wr_pg;
		t_refuse;
		conclude;
	end
endmodule // tb_tag_block_access_cmds
bind tba_core tba_chk u_chk (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_tx_ready(i_tx_ready),
	.o_tx_valid(o_tx_valid), .o_tx_data(o_tx_data), .i_auth_valid(i_auth_valid),
	.i_auth_blk(i_auth_blk), .i_tag_present(i_tag_present), .o_tag_req(o_tag_req),
	.o_tag_op(o_tag_op), .o_tag_blk(o_tag_blk), .o_tag_wdata(o_tag_wdata),
	.i_tag_done(i_tag_done), .i_tag_ok(i_tag_ok), .o_busy(o_busy));
